// ### pkg/aswd_pkg.sv
// aswd_pkg: constants and types of the standby / write dma command logic
// assumes one drive clock; the task-file decoder sits on the same clock
// What this block does
// - standby opcode: busy, sleep, clear busy and interrupt at once
// - standby immediate opcode behaves exactly like standby
// - any later command wakes the drive; reset_n low also clears sleep
// - translate sector does nothing and returns zero sector count
// - write buffer overwrites the sector buffer with one 512-byte block
// - write dma moves 1 to 256 sectors, count zero means 256
// - write dma starts at the sector addressed by the task file
// - write dma sets busy while buffering, then data request, clear busy
// - dma request follows media ready one clock late during the transfer
// - write dma interrupts only at the end or on a fatal error
// - on success the task file holds the last sector written
// - on error stop at failing sector and report its address
// - write dma in 8-bit mode is aborted with an error
// - pio write: busy on accept, then data request, clear busy, wait
package aswd_pkg;

  // opcodes
  localparam logic [7:0] OP_STANDBY_A   = 8'h96;
  localparam logic [7:0] OP_STANDBY_B   = 8'he2;
  localparam logic [7:0] OP_STBY_IMM_A  = 8'h94;
  localparam logic [7:0] OP_STBY_IMM_B  = 8'he0;
  localparam logic [7:0] OP_TRANSLATE   = 8'h87;
  localparam logic [7:0] OP_WRITE_BUF   = 8'he8;
  localparam logic [7:0] OP_WRITE_DMA   = 8'hca;

  // transfer geometry: 512 bytes per sector, 16-bit words
  localparam logic [7:0] LAST_WORD      = 8'hff;
  localparam logic [8:0] SECT_MAX       = 9'h100;
  localparam logic [7:0] XLAT_CNT       = 8'h00;

  // reset values
  localparam logic [27:0] ADDR_RST      = 28'h0000000;
  localparam logic [15:0] WORD_RST      = 16'h0000;

  typedef struct packed {
    logic [7:0] command;
    logic [7:0] features;
    logic [7:0] sect_cnt;
    logic [7:0] sect_num;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] drv_head;
  } aswd_tf_t;

  typedef struct packed {
    logic        dmack_n;
    logic        iowr_n;
    logic [15:0] dd;
  } aswd_pins_t;

  localparam aswd_pins_t PINS_RST = '{dmack_n: 1'b1, iowr_n: 1'b1,
                                      dd: 16'h0000};

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SBY,
    ST_WB_ACC,
    ST_WB_XFER,
    ST_WB_DONE,
    ST_DMA_PREP,
    ST_DMA_XFER
  } aswd_state_t;

endpackage

// ### design/aswd_sync.sv
// aswd_sync: two-stage synchroniser for the host dma pins
// assumes the pins are asynchronous to sys_clk
`timescale 1ns/10ps
module aswd_sync (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  // pins in, synchronised out
  input  wire aswd_pkg::aswd_pins_t pins,
  output      aswd_pkg::aswd_pins_t pins_sync
);

  typedef struct packed {
    aswd_pkg::aswd_pins_t first;
    aswd_pkg::aswd_pins_t second;
  } aswd_sync_t;

  aswd_sync_t st;
  aswd_sync_t next_st;

  always_comb
  begin
    next_st.first  = pins;
    next_st.second = st.first;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st.first  <= aswd_pkg::PINS_RST;
      st.second <= aswd_pkg::PINS_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pins_sync = st.second;

endmodule // aswd_sync

// ### design/aswd_cmd.sv
// aswd_cmd: drive-side standby, translate, write buffer, write dma logic
// assumes task-file strobes come from same-clock logic, dma pins do not
`timescale 1ns/10ps
module aswd_cmd (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  // task file from host decoder
  input  wire logic                 cmd_wr,
  input  wire aswd_pkg::aswd_tf_t   tf,
  input  wire logic                 status_rd,
  input  wire logic                 eight_bit_en,
  input  wire logic                 pio_wr,
  input  wire logic [15:0]          pio_data,
  // host dma pins
  input  wire aswd_pkg::aswd_pins_t host_pins,
  // media side
  input  wire logic                 media_ready,
  input  wire logic                 media_err,
  // status out
  output      logic                 busy,
  output      logic                 drq,
  output      logic                 err,
  output      logic                 abrt,
  output      logic                 intrq,
  output      logic                 sleep,
  output      logic                 dmarq,
  // task-file write back
  output      logic                 tf_load,
  output      logic [7:0]           tf_cnt_out,
  output      logic [27:0]          tf_addr_out,
  // sector buffer writes
  output      logic [15:0]          buf_word,
  output      logic                 buf_we,
  output      logic                 sect_done
);

  typedef struct packed {
    aswd_pkg::aswd_state_t state;
    logic        sleep;
    logic        busy;
    logic        drq;
    logic        err;
    logic        abrt;
    logic        intrq;
    logic        dmarq;
    logic        tf_load;
    logic [7:0]  tf_cnt_out;
    logic [27:0] tf_addr_out;
    logic [27:0] addr;
    logic [8:0]  remaining;
    logic [7:0]  word_cnt;
    logic [15:0] buf_word;
    logic        buf_we;
    logic        sect_done;
    logic        iowr_prev;
  } aswd_cmd_t;

  aswd_cmd_t            st;
  aswd_cmd_t            next_st;
  aswd_pkg::aswd_pins_t pins_s;
  logic                 dma_word;
  logic                 last_word;
  logic                 is_standby;
  logic                 is_stby_imm;

  aswd_sync u_sync (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .pins      (host_pins),
    .pins_sync (pins_s)
  );

  // host write strobe falling edge while acknowledged
  assign dma_word = !pins_s.dmack_n && !pins_s.iowr_n && st.iowr_prev;
  assign last_word = st.word_cnt == aswd_pkg::LAST_WORD;
  assign is_standby  = tf.command == aswd_pkg::OP_STANDBY_A ||
                       tf.command == aswd_pkg::OP_STANDBY_B;
  assign is_stby_imm = tf.command == aswd_pkg::OP_STBY_IMM_A ||
                       tf.command == aswd_pkg::OP_STBY_IMM_B;

  always_comb
  begin
    next_st           = st;
    next_st.tf_load   = 1'b0;
    next_st.buf_we    = 1'b0;
    next_st.sect_done = 1'b0;
    next_st.iowr_prev = pins_s.iowr_n;
    // reading status clears the interrupt; later sets override
    if (status_rd)
      next_st.intrq = 1'b0;
    case (st.state)
      aswd_pkg::ST_IDLE:
      begin
        if (cmd_wr)
        begin
          // only the opcode and needed fields are decoded
          next_st.sleep = 1'b0;
          next_st.intrq = 1'b0;
          next_st.err   = 1'b0;
          next_st.abrt  = 1'b0;
          if (is_standby || is_stby_imm)
          begin
            next_st.busy  = 1'b1;
            next_st.state = aswd_pkg::ST_SBY;
          end
          else if (tf.command == aswd_pkg::OP_TRANSLATE)
          begin
            next_st.tf_cnt_out = aswd_pkg::XLAT_CNT;
            next_st.tf_load    = 1'b1;
            next_st.tf_addr_out = {tf.drv_head[3:0], tf.cyl_hi, tf.cyl_lo,
                                   tf.sect_num};
            next_st.intrq      = 1'b1;
          end
          else if (tf.command == aswd_pkg::OP_WRITE_BUF)
          begin
            next_st.busy     = 1'b1;
            next_st.word_cnt = 8'h00;
            next_st.state    = aswd_pkg::ST_WB_ACC;
          end
          else if (tf.command == aswd_pkg::OP_WRITE_DMA && eight_bit_en)
          begin
            next_st.err   = 1'b1;
            next_st.abrt  = 1'b1;
            next_st.intrq = 1'b1;
          end
          else if (tf.command == aswd_pkg::OP_WRITE_DMA)
          begin
            next_st.busy      = 1'b1;
            next_st.addr      = {tf.drv_head[3:0], tf.cyl_hi, tf.cyl_lo,
                                 tf.sect_num};
            next_st.remaining = (tf.sect_cnt == 8'h00) ?
                                aswd_pkg::SECT_MAX : {1'b0, tf.sect_cnt};
            next_st.word_cnt  = 8'h00;
            next_st.state     = aswd_pkg::ST_DMA_PREP;
          end
          else
          begin
            next_st.err   = 1'b1;
            next_st.abrt  = 1'b1;
            next_st.intrq = 1'b1;
          end
        end
      end
      aswd_pkg::ST_SBY:
      begin
        next_st.busy  = 1'b0;
        next_st.sleep = 1'b1;
        next_st.intrq = 1'b1;
        next_st.state = aswd_pkg::ST_IDLE;
      end
      aswd_pkg::ST_WB_ACC:
      begin
        next_st.busy  = 1'b0;
        next_st.drq   = 1'b1;
        next_st.state = aswd_pkg::ST_WB_XFER;
      end
      aswd_pkg::ST_WB_XFER:
      begin
        if (pio_wr)
        begin
          next_st.buf_word = pio_data;
          next_st.buf_we   = 1'b1;
          next_st.word_cnt = st.word_cnt + 8'h01;
          if (last_word)
          begin
            next_st.drq   = 1'b0;
            next_st.busy  = 1'b1;
            next_st.state = aswd_pkg::ST_WB_DONE;
          end
        end
      end
      aswd_pkg::ST_WB_DONE:
      begin
        next_st.busy  = 1'b0;
        next_st.intrq = 1'b1;
        next_st.state = aswd_pkg::ST_IDLE;
      end
      aswd_pkg::ST_DMA_PREP:
      begin
        if (media_err)
        begin
          next_st.busy        = 1'b0;
          next_st.err         = 1'b1;
          next_st.intrq       = 1'b1;
          next_st.tf_load     = 1'b1;
          next_st.tf_addr_out = st.addr;
          next_st.tf_cnt_out  = st.remaining[7:0];
          next_st.state       = aswd_pkg::ST_IDLE;
        end
        else if (media_ready)
        begin
          next_st.busy  = 1'b0;
          next_st.drq   = 1'b1;
          next_st.dmarq = 1'b1;
          next_st.state = aswd_pkg::ST_DMA_XFER;
        end
      end
      aswd_pkg::ST_DMA_XFER:
      begin
        next_st.dmarq = media_ready;
        if (media_err)
        begin
          next_st.drq         = 1'b0;
          next_st.dmarq       = 1'b0;
          next_st.err         = 1'b1;
          next_st.intrq       = 1'b1;
          next_st.tf_load     = 1'b1;
          next_st.tf_addr_out = st.addr;
          next_st.tf_cnt_out  = st.remaining[7:0];
          next_st.state       = aswd_pkg::ST_IDLE;
        end
        else if (dma_word)
        begin
          next_st.buf_word = pins_s.dd;
          next_st.buf_we   = 1'b1;
          next_st.word_cnt = st.word_cnt + 8'h01;
          if (last_word)
          begin
            next_st.sect_done = 1'b1;
            if (st.remaining == 9'h001)
            begin
              next_st.drq         = 1'b0;
              next_st.dmarq       = 1'b0;
              next_st.intrq       = 1'b1;
              next_st.tf_load     = 1'b1;
              next_st.tf_addr_out = st.addr;
              next_st.tf_cnt_out  = 8'h00;
              next_st.state       = aswd_pkg::ST_IDLE;
            end
            else
            begin
              next_st.remaining = st.remaining - 9'h001;
              next_st.addr      = st.addr + 28'h0000001;
            end
          end
        end
      end
      default:
      begin
        next_st.state = aswd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st           <= '0;
      st.state     <= aswd_pkg::ST_IDLE;
      st.addr      <= aswd_pkg::ADDR_RST;
      st.buf_word  <= aswd_pkg::WORD_RST;
      st.iowr_prev <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign busy        = st.busy;
  assign drq         = st.drq;
  assign err         = st.err;
  assign abrt        = st.abrt;
  assign intrq       = st.intrq;
  assign sleep       = st.sleep;
  assign dmarq       = st.dmarq;
  assign tf_load     = st.tf_load;
  assign tf_cnt_out  = st.tf_cnt_out;
  assign tf_addr_out = st.tf_addr_out;
  assign buf_word    = st.buf_word;
  assign buf_we      = st.buf_we;
  assign sect_done   = st.sect_done;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  logic idle_cmd;
  assign idle_cmd = cmd_wr && st.state == aswd_pkg::ST_IDLE;

  sequence s_sleep_done;
    !busy && sleep && intrq;
  endsequence

  property p_standby;
    idle_cmd && is_standby |=> busy ##1 s_sleep_done;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby did not sleep and interrupt");

  property p_stby_imm;
    idle_cmd && is_stby_imm |=> busy ##1 s_sleep_done;
  endproperty
  a_stby_imm: assert property (p_stby_imm)
    else $error("standby immediate did not sleep and interrupt");

  property p_wake;
    sleep && idle_cmd && !is_standby && !is_stby_imm |=> !sleep;
  endproperty
  a_wake: assert property (p_wake)
    else $error("drive stayed asleep after a command");

  property p_translate;
    idle_cmd && tf.command == aswd_pkg::OP_TRANSLATE
      |=> tf_load && tf_cnt_out == 8'h00 && intrq && !busy;
  endproperty
  a_translate: assert property (p_translate)
    else $error("translate sector did not return zero count");

  property p_wbuf_end;
    st.state == aswd_pkg::ST_WB_XFER && pio_wr && st.word_cnt == 8'hff
      |=> busy && !drq ##1 intrq && !busy;
  endproperty
  a_wbuf_end: assert property (p_wbuf_end)
    else $error("write buffer did not end after 256 words");

  property p_pio_start;
    idle_cmd && tf.command == aswd_pkg::OP_WRITE_BUF
      |=> busy && !drq ##1 drq && !busy;
  endproperty
  a_pio_start: assert property (p_pio_start)
    else $error("pio write start sequence wrong");

  property p_count_zero;
    idle_cmd && tf.command == aswd_pkg::OP_WRITE_DMA && !eight_bit_en &&
      tf.sect_cnt == 8'h00 |=> st.remaining == 9'h100;
  endproperty
  a_count_zero: assert property (p_count_zero)
    else $error("sector count zero not taken as 256");

  property p_dma_prep;
    idle_cmd && tf.command == aswd_pkg::OP_WRITE_DMA && !eight_bit_en
      |=> busy && !dmarq && !intrq;
  endproperty
  a_dma_prep: assert property (p_dma_prep)
    else $error("write dma did not set busy while preparing");

  property p_dmarq;
    dmarq |-> $past(media_ready) && st.state == aswd_pkg::ST_DMA_XFER;
  endproperty
  a_dmarq: assert property (p_dmarq)
    else $error("dma request without room for data");

  property p_no_sector_irq;
    st.state == aswd_pkg::ST_DMA_XFER && !media_err &&
      !(dma_word && last_word && st.remaining == 9'h001) && !intrq
      |=> !intrq;
  endproperty
  a_no_sector_irq: assert property (p_no_sector_irq)
    else $error("interrupt raised in the middle of write dma");

  property p_last_addr;
    st.state == aswd_pkg::ST_DMA_XFER && !media_err && dma_word &&
      last_word && st.remaining == 9'h001
      |=> tf_load && !err && intrq && tf_addr_out == $past(st.addr);
  endproperty
  a_last_addr: assert property (p_last_addr)
    else $error("final address not reported after write dma");

  property p_err_addr;
    st.state == aswd_pkg::ST_DMA_XFER && media_err
      |=> err && intrq && !dmarq && tf_addr_out == $past(st.addr);
  endproperty
  a_err_addr: assert property (p_err_addr)
    else $error("failing sector not reported on write dma error");

  property p_eight_bit;
    idle_cmd && tf.command == aswd_pkg::OP_WRITE_DMA && eight_bit_en
      |=> err && abrt && intrq && !busy && !dmarq;
  endproperty
  a_eight_bit: assert property (p_eight_bit)
    else $error("write dma in 8-bit mode not aborted");

endmodule // aswd_cmd

// ### bench/aswd_host.sv
// aswd_host: host side of the dma handshake, one iowr pulse per word
// assumes dmarq is registered on sys_clk by the drive
`timescale 1ns/10ps
module aswd_host (
  // clock
  input  wire logic                 sys_clk,
  // drive request
  input  wire logic                 dmarq,
  // host pins
  output      aswd_pkg::aswd_pins_t pins
);
  initial pins = aswd_pkg::PINS_RST;

  // sends n words from base upward; quits when dmarq stays low too long
  task automatic send(input int n, input logic [15:0] base);
    int w;
    for (int i = 0; i < n; i++)
    begin
      w = 0;
      while (dmarq !== 1'b1 && w < 200)
      begin
        @(posedge sys_clk);
        w++;
      end
      if (dmarq !== 1'b1)
        break;
      pins.dmack_n <= 1'b0;
      pins.dd      <= base + 16'(i);
      repeat (3) @(posedge sys_clk);
      pins.iowr_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      pins.iowr_n <= 1'b1;
      // released bus does not keep the old word
      pins.dd     <= ~(base + 16'(i));
      repeat (3) @(posedge sys_clk);
    end
    pins.dmack_n <= 1'b1;
  endtask
endmodule // aswd_host

// ### bench/ata_standby_and_write_dma_cmds_tb.sv
// ata_standby_and_write_dma_cmds_tb: self-checking bench for aswd_cmd
// assumes aswd_host plays the host on the dma pins
`timescale 1ns/10ps
module ata_standby_and_write_dma_cmds_tb;
  logic                 sys_clk      = 1'b0;
  logic                 reset_n      = 1'b0;
  logic                 cmd_wr       = 1'b0;
  aswd_pkg::aswd_tf_t   tf           = '0;
  logic                 status_rd    = 1'b0;
  logic                 eight_bit_en = 1'b0;
  logic                 pio_wr       = 1'b0;
  logic [15:0]          pio_data     = 16'h0000;
  logic                 media_ready  = 1'b0;
  logic                 media_err    = 1'b0;
  aswd_pkg::aswd_pins_t host_pins;
  logic                 busy, drq, err, abrt, intrq, sleep, dmarq;
  logic                 tf_load, buf_we, sect_done, irq_q;
  logic [7:0]           tf_cnt_out;
  logic [27:0]          tf_addr_out;
  logic [15:0]          buf_word, last_word;
  int                   miscompares, tests_run, n_we, n_sd, n_irq;

  always #10 sys_clk = ~sys_clk;

  aswd_cmd dut (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_wr(cmd_wr),
    .tf(tf), .status_rd(status_rd), .eight_bit_en(eight_bit_en),
    .pio_wr(pio_wr), .pio_data(pio_data), .host_pins(host_pins),
    .media_ready(media_ready), .media_err(media_err), .busy(busy),
    .drq(drq), .err(err), .abrt(abrt), .intrq(intrq), .sleep(sleep),
    .dmarq(dmarq), .tf_load(tf_load), .tf_cnt_out(tf_cnt_out),
    .tf_addr_out(tf_addr_out), .buf_word(buf_word), .buf_we(buf_we),
    .sect_done(sect_done));

  aswd_host host (.sys_clk(sys_clk), .dmarq(dmarq), .pins(host_pins));

  initial
  begin
    {miscompares, tests_run, n_we, n_sd, n_irq} = '0;
    irq_q = 1'b0;
  end

  always @(posedge sys_clk)
  begin
    if (buf_we === 1'b1)
    begin
      n_we++;
      last_word = buf_word;
    end
    if (sect_done === 1'b1)
      n_sd++;
    if (intrq === 1'b1 && irq_q !== 1'b1)
      n_irq++;
    irq_q = intrq;
  end

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return busy;
      1: return drq;
      2: return intrq;
      default: return tf_load;
    endcase
  endfunction

  task automatic wait_hi(input int s, input int n);
    for (int i = 0; i < n; i++)
    begin
      #1;
      if (pick(s) === 1'b1)
        return;
      @(posedge sys_clk);
    end
    miscompares++;
    $display("unexpected wait %0d: expected 1 seen timeout", s);
    tally_and_finish();
  endtask

  task automatic issue(input logic [7:0] op, input logic [7:0] cnt,
                       input logic [27:0] a);
    @(posedge sys_clk);
    cmd_wr <= 1'b1;
    tf     <= '{command: op, features: 8'h5a, sect_cnt: cnt,
                sect_num: a[7:0], cyl_lo: a[15:8], cyl_hi: a[23:16],
                drv_head: {4'he, a[27:24]}};
    @(posedge sys_clk);
    cmd_wr <= 1'b0;
  endtask

  task automatic clear_irq;
    @(posedge sys_clk);
    status_rd <= 1'b1;
    @(posedge sys_clk);
    status_rd <= 1'b0;
    @(posedge sys_clk);
    #1;
    check("intrq cleared", intrq, 1'b0);
  endtask

  task automatic t_standby;
    logic [7:0] ops [4];
    ops = '{8'h96, 8'he2, 8'h94, 8'he0};
    foreach (ops[k])
    begin
      issue(ops[k], 8'h33, 28'h7a5c3e1);
      wait_hi(0, 3);
      wait_hi(2, 3);
      check("standby busy", busy, 1'b0);
      check("standby sleep", sleep, 1'b1);
      clear_irq();
    end
    $display("test standby done");
  endtask

  task automatic t_translate;
    issue(8'h87, 8'h5a, 28'h53cb2ff);
    wait_hi(3, 3);
    check("translate count", tf_cnt_out, 8'h00);
    wait_hi(2, 3);
    check("sleep after command", sleep, 1'b0);
    check("translate err", err, 1'b0);
    clear_irq();
    $display("test translate done");
  endtask

  task automatic t_wbuf;
    int b;
    b = n_we;
    issue(8'he8, 8'h00, 28'h0000000);
    wait_hi(0, 3);
    wait_hi(1, 4);
    check("write buffer busy", busy, 1'b0);
    for (int i = 0; i < 256; i++)
    begin
      @(posedge sys_clk);
      pio_wr   <= 1'b1;
      pio_data <= 16'ha500 + 16'(i);
    end
    @(posedge sys_clk);
    pio_wr <= 1'b0;
    wait_hi(2, 6);
    @(posedge sys_clk);
    #1;
    check("write buffer words", n_we - b, 256);
    check("write buffer last", last_word, 16'ha5ff);
    check("write buffer drq", drq, 1'b0);
    clear_irq();
    $display("test write buffer done");
  endtask

  task automatic t_abort;
    @(posedge sys_clk);
    eight_bit_en <= 1'b1;
    issue(8'hca, 8'h01, 28'h0001020);
    wait_hi(2, 3);
    check("8-bit err", err, 1'b1);
    check("8-bit abrt", abrt, 1'b1);
    check("8-bit dmarq", dmarq, 1'b0);
    @(posedge sys_clk);
    eight_bit_en <= 1'b0;
    clear_irq();
    $display("test dma abort done");
  endtask

  task automatic t_dma_ok;
    int bw, bs, bi, w;
    bw = n_we;
    bs = n_sd;
    bi = n_irq;
    @(posedge sys_clk);
    media_ready <= 1'b1;
    issue(8'hca, 8'h02, 28'h53cb2ff);
    wait_hi(0, 3);
    fork
      host.send(512, 16'h1000);
      begin
        for (w = 0; w < 3000 && n_we - bw < 100; w++)
          @(posedge sys_clk);
        check("dma words wait", w < 3000, 1'b1);
        media_ready <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        check("dmarq held off", dmarq, 1'b0);
        repeat (10) @(posedge sys_clk);
        media_ready <= 1'b1;
      end
    join
    wait_hi(2, 20);
    @(posedge sys_clk);
    #1;
    check("dma words", n_we - bw, 512);
    check("dma sectors", n_sd - bs, 2);
    check("dma interrupts", n_irq - bi, 1);
    check("dma last address", tf_addr_out, 28'h53cb300);
    check("dma end count", tf_cnt_out, 8'h00);
    check("dma last word", last_word, 16'h11ff);
    check("dma err", err, 1'b0);
    check("dma dmarq", dmarq, 1'b0);
    clear_irq();
    $display("test dma done");
  endtask

  task automatic t_dma_err;
    int bs, w;
    bs = n_sd;
    issue(8'hca, 8'h00, 28'h0001020);
    fork
      host.send(512, 16'h2000);
      begin
        for (w = 0; w < 3000 && n_sd == bs; w++)
          @(posedge sys_clk);
        check("dma sector wait", w < 3000, 1'b1);
        repeat (20) @(posedge sys_clk);
        media_err <= 1'b1;
        @(posedge sys_clk);
        media_err <= 1'b0;
      end
    join
    wait_hi(2, 5);
    check("error address", tf_addr_out, 28'h0001021);
    check("error remaining", tf_cnt_out, 8'hff);
    check("error flag", err, 1'b1);
    check("error dmarq", dmarq, 1'b0);
    $display("test dma error done");
  endtask

  initial
  begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_standby();
    t_translate();
    t_wbuf();
    t_abort();
    t_dma_ok();
    t_dma_err();
    tally_and_finish();
  end
endmodule // ata_standby_and_write_dma_cmds_tb
